// File: inc/pe_status_defs.vh
// Constants for the processing element status controller
`ifndef PE_STATUS_DEFS_VH
`define PE_STATUS_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_STATE       12'h000
`define REG_ASSIGN      12'h004
`define REG_MODE        12'h008
`define REG_IRQ_STATUS  12'h00c
`define REG_IRQ_MASK    12'h010
`define REG_CMD         12'h014

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define MODE_SIMPLEX    2'd0
`define MODE_DUPLEX     2'd1
`define MODE_TRIPLE     2'd2
`define CMD_EMERGENCY   8
`define IRQ_FAIL_PEND   0
`define IRQ_FAILED      4
`define IRQ_STOP        8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STOP_TIMEOUT_US    100
`define CLK_PERIOD_NS      10
`define STOP_TIMEOUT_CYC   ((`STOP_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)

`endif

// File: rtl/pe_status_ctrl.v
// Top of the processing element status controller with AHB-Lite slave
//
// Behaviour
// [RL1] Four independent status machines, one per processing element.
// [RL2] Each machine holds spare, normal, abnormal, failure pending or failed.
// [RL3] Each drives one stream bit; 12 bit assignment goes to every element.
// [RL4] Power up puts every machine in spare.
// [RL5] Panel assignment moves selected machines into active normal.
// [RL6] Fault implicating an element moves its machine to active abnormal.
// [RL7] Simplex, or duplex memory-only fault: stop interrupt at once.
// [RL8] Triple or duplex internal fault: stop on pace or timeout, first wins.
// [RL9] Pace before further fault returns abnormal to active normal.
// [RL10] Further fault before pace moves abnormal to failure pending.
// [RL11] Granted replacement moves stream to spare, faulty machine to failed.
// [RL12] Denied replacement returns failure pending to active abnormal.
// [RL13] Stop interrupts precede panel assignment updates and emergencies.
// [RL14] Stop timeout counts clock cycles, loaded entering active abnormal.
`timescale 1ns/1ns
`default_nettype none
`include "pe_status_defs.vh"

module pe_status_ctrl #(
   parameter NUM_PE      = 4,
   parameter TIMEOUT_CYC = `STOP_TIMEOUT_CYC
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire [3:0]  panel_assign,
   input  wire [3:0]  fault_pe,
   input  wire [3:0]  fault_mem,
   input  wire [3:0]  pace,
   input  wire [3:0]  reconfig_grant,
   input  wire [3:0]  reconfig_deny,
   input  wire [3:0]  spare_target,
   input  wire        emergency,
   output reg  [11:0] stream_assign,
   output reg  [3:0]  stop_irq,
   output reg  [3:0]  fail_pending,
   output reg         irq
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam SW = 30;
   reg [SW-1:0] sync1_q;
   reg [SW-1:0] sync2_q;
   wire [3:0] s_assign = sync2_q[3:0];
   wire [3:0] s_fpe    = sync2_q[7:4];
   wire [3:0] s_fmem   = sync2_q[11:8];
   wire [3:0] s_pace   = sync2_q[15:12];
   wire [3:0] s_grant  = sync2_q[19:16];
   wire [3:0] s_deny   = sync2_q[23:20];
   wire [3:0] s_spare  = sync2_q[27:24];
   wire       s_emerg  = sync2_q[28];

   // Two flops per pin before any logic
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= {SW{1'b0}};
         sync2_q <= {SW{1'b0}};
      end else begin
         sync1_q <= {1'b0, emergency, spare_target, reconfig_deny, reconfig_grant,
                     pace, fault_mem, fault_pe, panel_assign};
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   reg        wr_pend_q;
   reg [11:0] addr_q;
   reg [1:0]  mode_q [0:3];
   reg [7:0]  mode_flat_q;
   reg [11:0] irq_stat_q;
   reg [11:0] irq_mask_q;
   reg [3:0]  sw_assign_q;
   reg        sw_emerg_q;
   wire       take = hsel & hready & htrans[1];

   // Address phase capture; reads answered next cycle, zero wait
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 12'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready) begin
            wr_pend_q <= take & hwrite;
            addr_q    <= haddr[11:0];
         end
      end
   end

   wire [4:0] st0;
   wire [4:0] st1;
   wire [4:0] st2;
   wire [4:0] st3;
   wire [3:0] stop_w;
   wire [3:0] abit_w;
   wire [19:0] st_all = {st3, st2, st1, st0};

   // Read mux registered on the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (take && !hwrite) begin
         case (haddr[11:0])
            `REG_STATE:      hrdata <= {12'h000, st_all};
            `REG_ASSIGN:     hrdata <= {20'h00000, stream_assign};
            `REG_MODE:       hrdata <= {24'h000000, mode_flat_q};
            `REG_IRQ_STATUS: hrdata <= {20'h00000, irq_stat_q};
            `REG_IRQ_MASK:   hrdata <= {20'h00000, irq_mask_q};
            default:         hrdata <= 32'h00000000;
         endcase
      end
   end

   // Writable registers; command pulses last one cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_flat_q <= 8'h00;
         irq_mask_q  <= 12'h000;
         sw_assign_q <= 4'h0;
         sw_emerg_q  <= 1'b0;
      end else begin
         sw_assign_q <= 4'h0;
         sw_emerg_q  <= 1'b0;
         if (wr_pend_q) begin
            case (addr_q)
               `REG_MODE:     mode_flat_q <= hwdata[7:0];
               `REG_IRQ_MASK: irq_mask_q  <= hwdata[11:0];
               `REG_CMD: begin
                  sw_assign_q <= hwdata[3:0];
                  sw_emerg_q  <= hwdata[`CMD_EMERGENCY];
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Assignment sequencing: stop first, then assign
   // ----------------------------------------------------------------
   reg [3:0] assign_pend_q;
   reg [3:0] assign_go_q;
   reg [3:0] spare_on_q;
   wire [3:0] new_assign = s_assign | sw_assign_q;
   wire       stop_all = (|new_assign) | s_emerg | sw_emerg_q;  // RL13

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         assign_pend_q <= 4'h0;
         assign_go_q   <= 4'h0;
      end else begin
         assign_pend_q <= new_assign;
         assign_go_q   <= assign_pend_q;   // One cycle after stop went out
      end
   end

   // ----------------------------------------------------------------
   // Four status machines
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_PE; g = g + 1) begin : pe
         wire [4:0] st;
         pe_status_fsm #(
            .TIMEOUT_CYC (TIMEOUT_CYC)
         ) u_fsm (                                               // RL1
            .hclk         (hclk),
            .hresetn      (hresetn),
            .assign_req   (assign_go_q[g] | spare_on_q[g]),
            .fault_pe     (s_fpe[g]),
            .fault_mem    (s_fmem[g]),
            .pace         (s_pace[g]),
            .mode         (mode_q[g]),
            .grant        (s_grant[g]),
            .deny         (s_deny[g]),
            .ext_stop     (stop_all),
            .state_q      (st),
            .stop_req_q   (stop_w[g]),
            .assign_bit_q (abit_w[g])
         );
      end
   endgenerate
   assign st0 = pe[0].st;
   assign st1 = pe[1].st;
   assign st2 = pe[2].st;
   assign st3 = pe[3].st;

   // ----------------------------------------------------------------
   // Stream handover and outputs
   // ----------------------------------------------------------------
   // A granted failure assigns the named spare; its machine turns active normal
   // so the spare is tracked like any other active element
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         spare_on_q <= 4'h0;
      end else begin
         spare_on_q <= (|s_grant) ? s_spare : 4'h0;             // RL11
      end
   end

   // Stream word repeated three times, one copy per bus group
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stream_assign <= 12'h000;
         stop_irq      <= 4'h0;
         fail_pending  <= 4'h0;
      end else begin
         stream_assign <= {3{abit_w}};                          // RL3
         stop_irq      <= stop_w;
         fail_pending  <= {st3[3], st2[3], st1[3], st0[3]};
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, write one to clear, set wins
   // ----------------------------------------------------------------
   // Levels turned into entry events, so a clear is not undone by a standing state
   reg  [3:0]  pend_prev_q;
   reg  [3:0]  fail_prev_q;
   wire [3:0]  pend_now = {st3[3], st2[3], st1[3], st0[3]};
   wire [3:0]  fail_now = {st3[4], st2[4], st1[4], st0[4]};
   wire [11:0] ev = {stop_w, fail_now & ~fail_prev_q, pend_now & ~pend_prev_q};
   wire [11:0] w1c = (wr_pend_q && addr_q == `REG_IRQ_STATUS) ?
                     hwdata[11:0] : 12'h000;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_q  <= 12'h000;
         irq         <= 1'b0;
         pend_prev_q <= 4'h0;
         fail_prev_q <= 4'h0;
      end else begin
         pend_prev_q <= pend_now;
         fail_prev_q <= fail_now;
         irq_stat_q <= (irq_stat_q & ~w1c) | ev;
         irq        <= |(((irq_stat_q & ~w1c) | ev) & irq_mask_q);
      end
   end

   // Mode array decoded from the flat register, two bits per machine
   always @* begin
      mode_q[0] = mode_flat_q[1:0];
      mode_q[1] = mode_flat_q[3:2];
      mode_q[2] = mode_flat_q[5:4];
      mode_q[3] = mode_flat_q[7:6];
   end

endmodule // pe_status_ctrl

`default_nettype wire

// File: rtl/pe_status_fsm.v
// One status state machine for a single processing element
`timescale 1ns/1ns
`default_nettype none
`include "pe_status_defs.vh"

module pe_status_fsm #(
   parameter TIMEOUT_CYC = 10000
) (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       assign_req,
   input  wire       fault_pe,
   input  wire       fault_mem,
   input  wire       pace,
   input  wire [1:0] mode,
   input  wire       grant,
   input  wire       deny,
   input  wire       ext_stop,
   output reg  [4:0] state_q,
   output reg        stop_req_q,
   output reg        assign_bit_q
);

   // ----------------------------------------------------------------
   // States, one-hot
   // ----------------------------------------------------------------
   localparam [4:0] ST_SPARE    = 5'h01;
   localparam [4:0] ST_NORMAL   = 5'h02;
   localparam [4:0] ST_ABNORMAL = 5'h04;
   localparam [4:0] ST_PENDING  = 5'h08;
   localparam [4:0] ST_FAILED   = 5'h10;

   reg [4:0]  state_d;
   reg [31:0] timer_q;
   reg [31:0] timer_d;
   reg        armed_q;
   reg        armed_d;
   reg        stop_d;
   wire       fault = fault_pe | fault_mem;
   wire       timer_done = armed_q && (timer_q == 32'h00000001);

   // Next state and stop request
   always @* begin
      state_d = state_q;
      timer_d = timer_q;
      armed_d = armed_q;
      stop_d  = ext_stop & (state_q == ST_NORMAL);             // RL13
      if (armed_q && timer_q != 32'h00000000)
         timer_d = timer_q - 32'h00000001;
      case (state_q)
         ST_SPARE: begin
            if (assign_req)
               state_d = ST_NORMAL;                              // RL5
         end
         ST_NORMAL: begin
            if (fault) begin
               state_d = ST_ABNORMAL;                            // RL6
               // Immediate stop when no vote partner can mask it
               if (mode == `MODE_SIMPLEX ||
                   (mode == `MODE_DUPLEX && !fault_pe)) begin
                  stop_d  = 1'b1;                                // RL7
                  armed_d = 1'b0;
               end else begin
                  armed_d = 1'b1;                                // RL8
                  timer_d = TIMEOUT_CYC;                         // RL14
               end
            end
         end
         ST_ABNORMAL: begin
            if (armed_q && (pace || timer_done)) begin
               stop_d  = 1'b1;                                   // RL8
               armed_d = 1'b0;
            end
            // A further fault wins over a pace in the same cycle
            if (fault) begin
               state_d = ST_PENDING;                             // RL10
               armed_d = 1'b0;
            end else if (pace)
               state_d = ST_NORMAL;                              // RL9
         end
         ST_PENDING: begin
            if (grant)
               state_d = ST_FAILED;                              // RL11
            else if (deny)
               state_d = ST_ABNORMAL;                            // RL12
         end
         ST_FAILED: begin
            state_d = ST_FAILED;
         end
         default: begin
            state_d = ST_SPARE;
         end
      endcase
   end

   // State registers, spare after power up
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q      <= ST_SPARE;                               // RL4
         timer_q      <= 32'h00000000;
         armed_q      <= 1'b0;
         stop_req_q   <= 1'b0;
         assign_bit_q <= 1'b0;
      end else begin
         state_q      <= state_d;                                // RL2
         timer_q      <= timer_d;
         armed_q      <= armed_d;
         stop_req_q   <= stop_d;
         assign_bit_q <= (state_d == ST_NORMAL) |
                         (state_d == ST_ABNORMAL) |
                         (state_d == ST_PENDING);                // RL3
      end
   end

endmodule // pe_status_fsm

`default_nettype wire

// File: tb/pe_partner.sv
// Model of the elements and the reconfiguration decision
`timescale 1ns/1ns
`default_nettype none
module pe_partner (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [3:0]  stop_irq,
   input  wire logic [3:0]  fail_pending,
   input  wire logic [11:0] stream_assign,
   input  wire logic [3:0]  kick,
   input  wire logic [7:0]  lat,
   input  wire logic        allow,
   output logic      [3:0]  pace,
   output logic      [3:0]  grant,
   output logic      [3:0]  deny,
   output logic      [3:0]  spare
);
   logic [7:0] cnt_q [4];
   logic [7:0] wait_q;
   // Lowest passive element takes over on a grant
   assign spare = ~stream_assign[3:0] & (stream_assign[3:0] + 4'h1);
   // Stopped element paces lat cycles later; a decision holds until pending drops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pace   <= 4'h0;
         grant  <= 4'h0;
         deny   <= 4'h0;
         wait_q <= 8'h00;
         for (int i = 0; i < 4; i++) cnt_q[i] <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            pace[i]  <= kick[i] || cnt_q[i] == 8'h01;
            cnt_q[i] <= stop_irq[i] ? lat : cnt_q[i] - 8'(cnt_q[i] != 8'h00);
         end
         wait_q <= (fail_pending != 4'h0) ? wait_q + 8'h01 : 8'h00;
         grant  <= (wait_q == lat && allow) ? fail_pending : grant & fail_pending;
         deny   <= (wait_q == lat && !allow) ? fail_pending : deny & fail_pending;
      end
   end
endmodule // pe_partner
`default_nettype wire

// File: tb/pe_status_asserts.sv
// Port checker for the element status controller
`timescale 1ns/1ns
`default_nettype none
module pe_status_asserts (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic [3:0]  fault_pe,
   input wire logic [3:0]  fault_mem,
   input wire logic [3:0]  reconfig_grant,
   input wire logic [3:0]  reconfig_deny,
   input wire logic [11:0] stream_assign,
   input wire logic [3:0]  stop_irq,
   input wire logic [3:0]  fail_pending,
   input wire logic        irq
);
   logic [31:0] flt_q, dec_q;
   logic [3:0]  flt_any, dec_any;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Eight cycles of causes, enough to span the input sync and state update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flt_q <= 32'h0;
         dec_q <= 32'h0;
      end else begin
         flt_q <= {flt_q[27:0], fault_pe | fault_mem};
         dec_q <= {dec_q[27:0], reconfig_grant | reconfig_deny};
      end
   end
   // Any recent cause per element
   always_comb begin
      flt_any = 4'h0;
      dec_any = 4'h0;
      for (int k = 0; k < 8; k++) begin
         flt_any = flt_any | flt_q[4*k +: 4];
         dec_any = dec_any | dec_q[4*k +: 4];
      end
   end
   // Failure pending is left soon after a decision
   sequence s_left(k);
      ##[1:6] !fail_pending[k];
   endsequence
   AST_STREAM_COPIES:
      assert property (stream_assign == {3{stream_assign[3:0]}})
      else $error("stream copies differ");
   AST_RESET_SPARE:
      assert property ($rose(hresetn) |-> stream_assign == 12'h000 && fail_pending == 4'h0 && !irq)
      else $error("not idle after reset");
   AST_STOP_PULSE:
      assert property ((stop_irq & $past(stop_irq)) == 4'h0)
      else $error("stop longer than one cycle");
   AST_STOP_ACTIVE:
      assert property ((stop_irq & ~stream_assign[3:0]) == 4'h0)
      else $error("stop sent to passive element");
   for (genvar i = 0; i < 4; i++) begin : g_pe
      AST_PEND_CAUSE:
         assert property ($rose(fail_pending[i]) |-> flt_any[i])
         else $error("pending without fault");
      AST_PEND_EXIT:
         assert property ($fell(fail_pending[i]) |-> dec_any[i])
         else $error("pending left without decision");
      AST_GRANT_FAILS:
         assert property (fail_pending[i] && reconfig_grant[i]
            |-> s_left(i) ##[0:2] !stream_assign[i])
         else $error("grant kept faulty stream");
      AST_DENY_RETRY:
         assert property (fail_pending[i] && reconfig_deny[i] && !reconfig_grant[i]
            |-> s_left(i) ##0 stream_assign[i])
         else $error("deny dropped element");
   end
endmodule // pe_status_asserts
bind pe_status_ctrl pe_status_asserts u_chk (
   .hclk(hclk), .hresetn(hresetn), .fault_pe(fault_pe), .fault_mem(fault_mem),
   .reconfig_grant(reconfig_grant), .reconfig_deny(reconfig_deny),
   .stream_assign(stream_assign), .stop_irq(stop_irq), .fail_pending(fail_pending), .irq(irq));
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the element status controller
`timescale 1ns/1ns
`default_nettype none
`include "pe_status_defs.vh"
module tb;
   localparam int TO = 20;
   localparam logic [4:0] SP = 5'h01, NO = 5'h02, AB = 5'h04, PD = 5'h08, FL = 5'h10;
   localparam logic [23:0] CASES = 24'ha84731; // {mode, mem, immediate} per case
   logic        hclk, hresetn, hwrite, hreadyout, hresp, emergency, irq, allow;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [3:0]  panel_assign, fault_pe, fault_mem, pace, grant, deny, spare, stop_irq;
   logic [3:0]  fail_pending, kick, e;
   logic [11:0] stream_assign;
   logic [7:0]  lat, m;
   int          fails, compares, cyc, t;
   pe_status_ctrl #(.TIMEOUT_CYC(TO)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .panel_assign(panel_assign), .fault_pe(fault_pe),
      .fault_mem(fault_mem), .pace(pace), .reconfig_grant(grant), .reconfig_deny(deny),
      .spare_target(spare), .emergency(emergency), .stream_assign(stream_assign),
      .stop_irq(stop_irq), .fail_pending(fail_pending), .irq(irq));
   pe_partner u_far (.hclk(hclk), .hresetn(hresetn), .stop_irq(stop_irq),
      .fail_pending(fail_pending), .stream_assign(stream_assign), .kick(kick), .lat(lat),
      .allow(allow), .pace(pace), .grant(grant), .deny(deny), .spare(spare));
   function automatic logic [31:0] stw(input logic [4:0] a3, a2, a1, a0);
      return {12'h000, a3, a2, a1, a0};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (fails == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Single AHB-Lite word transfer; hsel stays high, so nothing toggles twice
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(d, exp);
   endtask
   // One-cycle pulse on a far-side pin, then one idle cycle
   task automatic hit(input logic [1:0] k, input logic [3:0] v);
      case (k)
         2'd0: panel_assign <= v;
         2'd1: fault_pe <= v;
         2'd2: fault_mem <= v;
         default: kick <= v;
      endcase
      @(posedge hclk);
      panel_assign <= 4'h0;
      fault_pe <= 4'h0;
      fault_mem <= 4'h0;
      kick <= 4'h0;
      @(posedge hclk);
   endtask
   task automatic wfor(ref logic [3:0] s, input int k, input logic v, input int lim);
      t = 0;
      do begin
         @(posedge hclk);
         t++;
      end while (s[k] !== v && t < lim);
   endtask
   always #5 hclk = ~hclk;
   // Hang guard
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      {hclk, hresetn, hwrite, emergency, allow, htrans, haddr, hwdata} = 0;
      {panel_assign, fault_pe, fault_mem, kick, fails, compares, cyc} = 0;
      lat = 8'h03;
      void'($urandom(55));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(`REG_STATE, stw(SP, SP, SP, SP));
      rchk(`REG_ASSIGN, 32'h0);
      rchk(12'h020, 32'h0);
      for (int i = 0; i < 4; i++) m[2*i +: 2] = 2'($urandom_range(2));
      bus(1'b1, `REG_MODE, {24'h0, m});
      rchk(`REG_MODE, {24'h0, m});
      bus(1'b1, `REG_MODE, 32'h0);
      hit(2'd0, 4'h3);
      repeat (6) @(posedge hclk);
      chk(32'(stream_assign), 32'h333);
      bus(1'b1, `REG_CMD, 32'h4);
      wfor(stop_irq, 0, 1'b1, 10);
      chk(32'({stop_irq, stream_assign[2]}), 32'h6);
      repeat (6) @(posedge hclk);
      rchk(`REG_STATE, stw(SP, NO, NO, NO));
      chk(32'(stream_assign), 32'h777);
      hit(2'd1, 4'h1);
      wfor(stop_irq, 0, 1'b1, 12);
      chk(32'(t <= 6), 32'h1);
      rchk(`REG_STATE, stw(SP, NO, NO, AB));
      repeat (12) @(posedge hclk);
      rchk(`REG_STATE, stw(SP, NO, NO, NO));
      // Each mode and fault source on element 2, partner pace at random speed
      for (int c = 0; c < 6; c++) begin
         e = CASES[4*c +: 4];
         lat <= 8'(2 + $urandom_range(3));
         bus(1'b1, `REG_MODE, {26'h0, e[3:2], 4'h0});
         hit(e[1] ? 2'd2 : 2'd1, 4'h4);
         wfor(stop_irq, 2, 1'b1, 60);
         chk(32'(e[0] ? t <= 6 : t >= TO - 2 && t <= TO + 6), 32'h1);
         repeat (20) @(posedge hclk);
         rchk(`REG_STATE, stw(SP, NO, NO, NO));
      end
      hit(2'd1, 4'h4);
      hit(2'd3, 4'h4);
      wfor(stop_irq, 2, 1'b1, 12);
      chk(32'(t <= 8), 32'h1);
      lat <= 8'd40;
      allow <= 1'b1;
      hit(2'd1, 4'h2);
      hit(2'd2, 4'h2);
      wfor(fail_pending, 1, 1'b1, 10);
      rchk(`REG_STATE, stw(SP, NO, PD, NO));
      chk(32'(irq), 32'h0);
      bus(1'b1, `REG_IRQ_MASK, 32'h2);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h1);
      wfor(fail_pending, 1, 1'b0, 80);
      repeat (4) @(posedge hclk);
      rchk(`REG_STATE, stw(NO, NO, FL, NO));
      chk(32'(stream_assign), 32'hddd);
      bus(1'b1, `REG_IRQ_STATUS, 32'hfff);
      rchk(`REG_IRQ_STATUS, 32'h0);
      lat <= 8'd20;
      allow <= 1'b0;
      hit(2'd1, 4'h1);
      hit(2'd1, 4'h1);
      wfor(fail_pending, 0, 1'b1, 10);
      wfor(fail_pending, 0, 1'b0, 60);
      rchk(`REG_STATE, stw(NO, NO, FL, AB));
      hit(2'd3, 4'h1);
      repeat (8) @(posedge hclk);
      rchk(`REG_STATE, stw(NO, NO, FL, NO));
      emergency <= 1'b1;
      @(posedge hclk);
      emergency <= 1'b0;
      wfor(stop_irq, 0, 1'b1, 10);
      chk(32'(stop_irq), 32'hd);
      repeat (30) @(posedge hclk);
      bus(1'b1, `REG_CMD, 32'h100);
      wfor(stop_irq, 0, 1'b1, 10);
      chk(32'(stop_irq), 32'hd);
      hit(2'd1, 4'h2);
      hit(2'd0, 4'h2);
      repeat (8) @(posedge hclk);
      chk(32'({stream_assign, fail_pending}), 32'hddd0);
      rchk(`REG_STATE, stw(NO, NO, FL, NO));
      chk(32'(hresp), 32'h0);
      stop_test();
   end
endmodule // tb
`default_nettype wire
